// *** test/gdr_link_monitor.sv ***
// link checker for the detector end answering the master
module gdr_link_monitor
	import gdr_pkg::*;
#(
	parameter logic [ID_W-1:0] MY_ID = 8'h05
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic req_vld,
	input wire logic req_wr,
	input wire logic [ID_W-1:0] req_id,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_data,
	input wire logic rsp_vld,
	input wire logic rsp_exc,
	input wire logic [DATA_W-1:0] rsp_data
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (srst_i);
	logic mine;
	logic clr;
	assign mine = req_vld && req_id == MY_ID;
	assign clr = req_addr == FIRST_RELAY_CLEAR || req_addr == SECOND_RELAY_CLEAR;
	////////////////////////////////////////////////////////////////////////
	a_answer_own_req: assert property (mine |=> rsp_vld)
		else $error("own request unanswered");
	a_bcast_silent: assert property (req_vld && req_id == BROADCAST_ID |=> !rsp_vld)
		else $error("answer to broadcast");
	a_rsp_has_cause: assert property (rsp_vld |-> $past(mine))
		else $error("answer without request");
	a_rsp_held: assert property (!rsp_vld |-> $stable(rsp_data) && $stable(rsp_exc))
		else $error("answer changed between strobes");
	a_ro_write_refused: assert property (mine && req_wr && !clr |=> ##0 rsp_exc
		&& rsp_data == EXC_BAD_ADDRESS)
		else $error("read-only write not refused");
	a_clear_reads_zero: assert property (mine && !req_wr && req_addr == FIRST_RELAY_CLEAR
		|=> !rsp_exc && rsp_data == WORD_ZERO)
		else $error("first clear read not zero");
	a_clear2_reads_zero: assert property (mine && !req_wr && req_addr == SECOND_RELAY_CLEAR
		|=> !rsp_exc && rsp_data == WORD_ZERO)
		else $error("second clear read not zero");
	a_clear_bad_value: assert property (mine && req_wr && clr && req_data > CLEAR_CMD
		|=> rsp_exc && rsp_data == EXC_BAD_VALUE)
		else $error("bad clear value accepted");
	a_clear_echo: assert property (mine && req_wr && clr && req_data <= CLEAR_CMD
		|=> !rsp_exc && rsp_data == $past(req_data))
		else $error("clear write not echoed");
	a_unlisted_refused: assert property (mine && (req_addr == 16'h0000
		|| req_addr > SECOND_RELAY_CLEAR) |=> rsp_exc && rsp_data == EXC_BAD_ADDRESS)
		else $error("unlisted address not refused");
	a_station_range: assert property (mine && !req_wr && req_addr == STATION_ADDRESS
		|=> !rsp_exc && rsp_data <= {8'h00, STATION_MAX})
		else $error("station address out of range");
endmodule // gdr_link_monitor

// *** test/tb.sv ***
// self-checking bench for master and detector ends
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb import gdr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [ID_W-1:0] MY_ID = 8'h05;
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1;
	int n_fail = 0;
	int samples_checked = 0;
	int seed = 32'h01203321;
	logic tbl_we = 1'b0, cmd_vld = 1'b0, cmd_wr = 1'b0;
	logic [4:0] tbl_node = 5'h00, cmd_node = 5'h00;
	logic [ID_W-1:0] tbl_id = 8'h00;
	logic [15:0] cmd_addr = 16'h0000, cmd_data = 16'h0000;
	logic [31:0] gas = 32'h0, sup = 32'h0, th1 = 32'h0, th2 = 32'h0, spn = 32'h0;
	logic [15:0] gk = 16'h0, uk = 16'h0, fma = 16'h0, fmi = 16'h0, tech = 16'h0;
	logic [15:0] dec = 16'h0, cal = 16'h0, dz = 16'h0, ds = 16'h0, rd, res_data;
	gdr_opstate_t ops = OPST_NORMAL;
	gdr_fault_t flt = FLT_NONE;
	logic [OPT_W-1:0] opts = 6'h30;
	logic [1:0] above = 2'b00, exp_act = 2'b00, act, coil;
	logic cmd_rdy, res_vld, res_exc, res_to, zn, sn, ex, tmo;
	logic [2:0] oc [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
	logic [2:0] fc [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
	always #4 clk_sys_i = ~clk_sys_i;
	////////////////////////////////////////////////////////////////////////
	gdr_link_if i_gdr_link_if (.clk_sys_i(clk_sys_i));
	gdr_master #(.TIMEOUT(8)) i_gdr_master (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.link(i_gdr_link_if), .tbl_we_i(tbl_we), .tbl_node_i(tbl_node), .tbl_id_i(tbl_id),
		.cmd_vld_i(cmd_vld), .cmd_node_i(cmd_node), .cmd_wr_i(cmd_wr), .cmd_addr_i(cmd_addr),
		.cmd_data_i(cmd_data), .cmd_rdy_o(cmd_rdy), .res_vld_o(res_vld), .res_exc_o(res_exc),
		.res_timeout_o(res_to), .res_data_o(res_data));
	gdr_detector i_gdr_detector (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.link(i_gdr_link_if), .station_i(MY_ID), .gas_value_i(gas), .supply_value_i(sup),
		.gas_kind_i(gk), .unit_kind_i(uk), .fw_major_i(fma), .fw_minor_i(fmi), .opstate_i(ops),
		.fault_i(flt), .technology_i(tech), .threshold1_i(th1), .threshold2_i(th2),
		.decimals_i(dec), .relay_opts_i(opts), .days_zero_i(dz), .cal_method_i(cal),
		.span_target_i(spn), .days_span_i(ds), .above_i(above), .relay_active_o(act),
		.relay_coil_o(coil), .zero_never_o(zn), .span_never_o(sn));
	gdr_link_monitor #(.MY_ID(MY_ID)) i_mon (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.req_vld(i_gdr_link_if.req_vld), .req_wr(i_gdr_link_if.req_wr),
		.req_id(i_gdr_link_if.req_id), .req_addr(i_gdr_link_if.req_addr),
		.req_data(i_gdr_link_if.req_data), .rsp_vld(i_gdr_link_if.rsp_vld),
		.rsp_exc(i_gdr_link_if.rsp_exc), .rsp_data(i_gdr_link_if.rsp_data));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [16:0] exp_rd(logic [15:0] a);
		logic [15:0] w [34];
		w = '{16'h0, gas[31:16], gas[15:0], {8'h00, MY_ID}, gk, uk, fma, fmi, {13'h0, ops},
			sup[31:16], sup[15:0], {13'h0, flt}, tech, 16'h0, th1[31:16], th1[15:0],
			th2[31:16], th2[15:0], 16'h0, 16'h0, 16'h0, 16'h0, dec, {10'h0, opts}, dz, cal,
			spn[31:16], spn[15:0], ds, 16'h0, {15'h0, exp_act[0]}, {15'h0, exp_act[1]},
			16'h0, 16'h0};
		if (!(a inside {[16'h0001:16'h000C], [16'h000E:16'h0011], [16'h0016:16'h001C],
			[16'h001E:16'h0021]})) begin
			return {1'b1, EXC_BAD_ADDRESS};
		end
		return {1'b0, w[a[5:0]]};
	endfunction
	function automatic logic [16:0] exp_wr(logic [15:0] a, logic [15:0] d);
		if (a != FIRST_RELAY_CLEAR && a != SECOND_RELAY_CLEAR) begin
			return {1'b1, EXC_BAD_ADDRESS};
		end
		return (d > CLEAR_CMD) ? {1'b1, EXC_BAD_VALUE} : {1'b0, d};
	endfunction
	task automatic xfer(input logic [4:0] n, input logic w, input logic [15:0] a, d);
		@(negedge clk_sys_i);
		cmd_vld = 1'b1;
		cmd_node = n;
		cmd_wr = w;
		cmd_addr = a;
		cmd_data = d;
		repeat (40) if (cmd_rdy !== 1'b1) @(negedge clk_sys_i);
		`CHK(cmd_rdy, 1'b1)
		@(negedge clk_sys_i);
		cmd_vld = 1'b0;
		repeat (40) if (res_vld !== 1'b1) @(negedge clk_sys_i);
		`CHK(res_vld, 1'b1)
		{tmo, ex, rd} = {res_to, res_exc, res_data};
	endtask
	task automatic relay_chk(input logic [1:0] e);
		exp_act = e;
		repeat (3) @(negedge clk_sys_i);
		`CHK(act, e)
		`CHK(coil, e ^ opts[3:2])
	endtask
	task automatic summarize;
		$display("checked=%0d failed=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (30000) @(negedge clk_sys_i);
		n_fail++;
		summarize();
	end
	initial begin
		repeat (5) @(negedge clk_sys_i);
		srst_i = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		tbl_we = 1'b1;
		tbl_id = MY_ID;
		@(negedge clk_sys_i);
		tbl_node = 5'h02;
		tbl_id = 8'h09;
		@(negedge clk_sys_i);
		tbl_we = 1'b0;
		for (int r = 0; r < 7; r++) begin
			{gas, sup, th1, th2, spn} = {$random(seed), $random(seed), $random(seed),
				$random(seed), $random(seed)};
			{gk, uk, fma, fmi, tech, dec, cal, dz} = {$random(seed), $random(seed),
				$random(seed), $random(seed)};
			ds = 16'($random(seed));
			opts = {2'b11, 4'($random(seed))};
			ops = gdr_opstate_t'(oc[r]);
			flt = gdr_fault_t'(fc[r % 5]);
			if (r < 2) begin
				dz = DAYS_LIMIT + 16'(r);
				ds = DAYS_LIMIT + 16'(1 - r);
			end
			for (logic [15:0] a = 16'h0000; a < 16'h0025; a++) begin
				cmd_data = {14'h0, 2'($random(seed))};
				xfer(5'h00, 1'b1, a, cmd_data);
				`CHK({tmo, ex, rd}, {1'b0, exp_wr(a, cmd_data)})
			end
			for (logic [15:0] a = 16'h0000; a < 16'h0025; a++) begin
				xfer(5'h00, 1'b0, a, 16'h0000);
				`CHK({tmo, ex, rd}, {1'b0, exp_rd(a)})
			end
			`CHK(zn, dz > DAYS_LIMIT)
			`CHK(sn, ds > DAYS_LIMIT)
		end
		xfer(5'h00, 1'b0, GAS_CONCENTRATION_VALUE, 16'h0000);
		`CHK({ex, rd}, exp_rd(GAS_CONCENTRATION_VALUE))
		gas = ~gas;
		xfer(5'h00, 1'b0, GAS_CONCENTRATION_VALUE + 16'h0001, 16'h0000);
		`CHK({ex, rd}, {1'b0, ~gas[15:0]})
		opts = 6'h37;
		above = 2'b11;
		relay_chk(2'b11);
		above = 2'b00;
		relay_chk(2'b11);
		xfer(5'h00, 1'b1, FIRST_RELAY_CLEAR, 16'h0000);
		relay_chk(2'b11);
		xfer(5'h00, 1'b1, FIRST_RELAY_CLEAR, 16'h0002);
		`CHK({ex, rd}, {1'b1, EXC_BAD_VALUE})
		xfer(5'h00, 1'b1, FIRST_RELAY_CLEAR, CLEAR_CMD);
		relay_chk(2'b10);
		xfer(5'h01, 1'b1, SECOND_RELAY_CLEAR, CLEAR_CMD);
		`CHK(tmo, 1'b0)
		relay_chk(2'b00);
		xfer(5'h00, 1'b0, FIRST_RELAY_ACTIVE, 16'h0000);
		`CHK({ex, rd}, exp_rd(FIRST_RELAY_ACTIVE))
		opts = 6'h0C;
		above = 2'b10;
		relay_chk(2'b01);
		opts = 6'h30;
		relay_chk(2'b10);
		@(negedge clk_sys_i);
		tbl_we = 1'b1;
		tbl_node = 5'h03;
		tbl_id = 8'hF8;
		@(negedge clk_sys_i);
		tbl_we = 1'b0;
		xfer(5'h03, 1'b0, GAS_CONCENTRATION_VALUE, 16'h00A5);
		`CHK({tmo, ex, rd}, {2'b00, 16'h00A5})
		xfer(5'h02, 1'b0, GAS_CONCENTRATION_VALUE, 16'h0000);
		`CHK({tmo, rd}, {1'b1, 16'h0000})
		summarize();
	end
endmodule // tb

// *** verilog/gdr_detector.sv ***
// detector end: register bank answering the master
module gdr_detector
	import gdr_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic srst_i,
	gdr_link_if.detector link,
	input wire logic [ID_W-1:0] station_i,
	input wire logic [FLT_W-1:0] gas_value_i,
	input wire logic [FLT_W-1:0] supply_value_i,
	input wire logic [DATA_W-1:0] gas_kind_i,
	input wire logic [DATA_W-1:0] unit_kind_i,
	input wire logic [DATA_W-1:0] fw_major_i,
	input wire logic [DATA_W-1:0] fw_minor_i,
	input wire gdr_opstate_t opstate_i,
	input wire gdr_fault_t fault_i,
	input wire logic [DATA_W-1:0] technology_i,
	input wire logic [FLT_W-1:0] threshold1_i,
	input wire logic [FLT_W-1:0] threshold2_i,
	input wire logic [DATA_W-1:0] decimals_i,
	input wire logic [OPT_W-1:0] relay_opts_i,
	input wire logic [DATA_W-1:0] days_zero_i,
	input wire logic [DATA_W-1:0] cal_method_i,
	input wire logic [FLT_W-1:0] span_target_i,
	input wire logic [DATA_W-1:0] days_span_i,
	input wire logic [1:0] above_i,
	output logic [1:0] relay_active_o,
	output logic [1:0] relay_coil_o,
	output logic zero_never_o,
	output logic span_never_o
);
	logic [ID_W-1:0] station_q;
	logic [DATA_W-1:0] lo_hold_q;
	logic [ADDR_W-1:0] lo_addr_q;
	logic lo_vld_q;
	logic [1:0] clear_q;
	logic rsp_vld_q;
	logic rsp_exc_q;
	logic [DATA_W-1:0] rsp_data_q;
	logic [1:0] clear_d;
	logic for_me;
	logic bcast;
	logic [DATA_W:0] word;
	logic [DATA_W-1:0] lo_word;
	logic is_hi;

	////////////////////////////////////////////////////////////////////////
	// map lookup

	function automatic logic [DATA_W:0] hit(input logic [DATA_W-1:0] v);
		hit = {1'b1, v};
	endfunction

	function automatic logic [DATA_W-1:0] hi16(input logic [FLT_W-1:0] v);
		hi16 = v[FLT_W-1:DATA_W];
	endfunction

	function automatic logic [DATA_W-1:0] lo16(input logic [FLT_W-1:0] v);
		lo16 = v[DATA_W-1:0];
	endfunction

	function automatic logic [DATA_W-1:0] code16(input logic [2:0] v);
		code16 = {13'h0000, v};
	endfunction

	function automatic logic [DATA_W-1:0] bit16(input logic v);
		bit16 = {15'h0000, v};
	endfunction

	// returns {listed, word}
	always_comb begin
		word = {1'b0, WORD_ZERO};
		lo_word = WORD_ZERO;
		is_hi = 1'b0;
		unique case (link.req_addr)
			GAS_CONCENTRATION_VALUE: begin
				word = hit(hi16(gas_value_i));
				lo_word = lo16(gas_value_i);
				is_hi = 1'b1;
			end
			GAS_CONCENTRATION_VALUE + 16'h0001: word = hit(lo16(gas_value_i));
			STATION_ADDRESS: word = hit({8'h00, station_q});
			GAS_KIND: word = hit(gas_kind_i);
			MEASUREMENT_UNIT_KIND: word = hit(unit_kind_i);
			FIRMWARE_MAJOR_VERSION: word = hit(fw_major_i);
			FIRMWARE_MINOR_VERSION: word = hit(fw_minor_i);
			OPERATING_STATE: word = hit(code16(opstate_i));
			SUPPLY_VOLTAGE_VALUE: begin
				word = hit(hi16(supply_value_i));
				lo_word = lo16(supply_value_i);
				is_hi = 1'b1;
			end
			SUPPLY_VOLTAGE_VALUE + 16'h0001: word = hit(lo16(supply_value_i));
			FAULT_CAUSE: word = hit(code16(fault_i));
			SENSING_TECHNOLOGY: word = hit(technology_i);
			FIRST_RELAY_THRESHOLD: begin
				word = hit(hi16(threshold1_i));
				lo_word = lo16(threshold1_i);
				is_hi = 1'b1;
			end
			FIRST_RELAY_THRESHOLD + 16'h0001: word = hit(lo16(threshold1_i));
			SECOND_RELAY_THRESHOLD: begin
				word = hit(hi16(threshold2_i));
				lo_word = lo16(threshold2_i);
				is_hi = 1'b1;
			end
			SECOND_RELAY_THRESHOLD + 16'h0001: word = hit(lo16(threshold2_i));
			DECIMAL_PLACES: word = hit(decimals_i);
			RELAY_OPTION_BITS: word = hit({10'h000, relay_opts_i});
			DAYS_SINCE_ZEROING: word = hit(days_zero_i);
			CALIBRATION_METHOD: word = hit(cal_method_i);
			AUTO_SPAN_TARGET: begin
				word = hit(hi16(span_target_i));
				lo_word = lo16(span_target_i);
				is_hi = 1'b1;
			end
			AUTO_SPAN_TARGET + 16'h0001: word = hit(lo16(span_target_i));
			DAYS_SINCE_SPAN: word = hit(days_span_i);
			FIRST_RELAY_ACTIVE: word = hit(bit16(relay_active_o[0]));
			SECOND_RELAY_ACTIVE: word = hit(bit16(relay_active_o[1]));
			FIRST_RELAY_CLEAR: word = hit(WORD_ZERO);
			SECOND_RELAY_CLEAR: word = hit(WORD_ZERO);
			default: word = {1'b0, WORD_ZERO};
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// addressing

	assign for_me = link.req_vld && (link.req_id == station_q);
	assign bcast = link.req_vld && (link.req_id == BROADCAST_ID) && link.req_wr;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			station_q <= STATION_MAX;
		end else begin
			station_q <= (station_i > STATION_MAX) ? STATION_MAX : station_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// relay clear writes

	always_comb begin
		clear_d = 2'b00;
		if ((for_me || bcast) && link.req_data == CLEAR_CMD) begin
			clear_d[0] = (link.req_addr == FIRST_RELAY_CLEAR);
			clear_d[1] = (link.req_addr == SECOND_RELAY_CLEAR);
		end
		if (!link.req_wr) begin
			clear_d = 2'b00;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			clear_q <= 2'b00;
		end else begin
			clear_q <= clear_d;
		end
	end

	gdr_relay_latch u_relay1 (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.above_i(above_i[0]),
		.rise_i(relay_opts_i[OPT_RISE_LSB]),
		.latch_i(relay_opts_i[OPT_LATCH_LSB]),
		.failsafe_i(relay_opts_i[OPT_FAILSAFE_LSB]),
		.clear_i(clear_q[0]),
		.active_o(relay_active_o[0]),
		.coil_o(relay_coil_o[0])
	);

	gdr_relay_latch u_relay2 (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.above_i(above_i[1]),
		.rise_i(relay_opts_i[OPT_RISE_LSB+1]),
		.latch_i(relay_opts_i[OPT_LATCH_LSB+1]),
		.failsafe_i(relay_opts_i[OPT_FAILSAFE_LSB+1]),
		.clear_i(clear_q[1]),
		.active_o(relay_active_o[1]),
		.coil_o(relay_coil_o[1])
	);

	////////////////////////////////////////////////////////////////////////
	// float low word held from the high word read

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			lo_vld_q <= 1'b0;
			lo_hold_q <= WORD_ZERO;
			lo_addr_q <= WORD_ZERO;
		end else if (for_me) begin
			lo_vld_q <= is_hi && !link.req_wr;
			lo_hold_q <= lo_word;
			lo_addr_q <= link.req_addr + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// response

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			rsp_vld_q <= 1'b0;
			rsp_exc_q <= 1'b0;
			rsp_data_q <= WORD_ZERO;
		end else begin
			rsp_vld_q <= for_me;
			if (for_me) begin
				rsp_exc_q <= 1'b0;
				rsp_data_q <= word[DATA_W-1:0];
				if (!word[DATA_W]) begin
					rsp_exc_q <= 1'b1;
					rsp_data_q <= EXC_BAD_ADDRESS;
				end else if (link.req_wr) begin
					rsp_data_q <= link.req_data;
					if (link.req_addr != FIRST_RELAY_CLEAR &&
						link.req_addr != SECOND_RELAY_CLEAR) begin
						rsp_exc_q <= 1'b1;
						rsp_data_q <= EXC_BAD_ADDRESS;
					end else if (link.req_data > CLEAR_CMD) begin
						rsp_exc_q <= 1'b1;
						rsp_data_q <= EXC_BAD_VALUE;
					end
				end else if (lo_vld_q && link.req_addr == lo_addr_q) begin
					rsp_data_q <= lo_hold_q;
				end
			end
		end
	end

	assign link.rsp_vld = rsp_vld_q;
	assign link.rsp_exc = rsp_exc_q;
	assign link.rsp_data = rsp_data_q;

	////////////////////////////////////////////////////////////////////////
	// never-performed flags

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			zero_never_o <= 1'b0;
			span_never_o <= 1'b0;
		end else begin
			zero_never_o <= (days_zero_i > DAYS_LIMIT);
			span_never_o <= (days_span_i > DAYS_LIMIT);
		end
	end
endmodule // gdr_detector

// *** verilog/gdr_link_if.sv ***
// register access link between master and detector
interface gdr_link_if (
	input wire logic clk_sys_i
);
	import gdr_pkg::*;
	logic req_vld;
	logic req_wr;
	logic [ID_W-1:0] req_id;
	logic [ADDR_W-1:0] req_addr;
	logic [DATA_W-1:0] req_data;
	logic rsp_vld;
	logic rsp_exc;
	logic [DATA_W-1:0] rsp_data;

	modport master (
		output req_vld, req_wr, req_id, req_addr, req_data,
		input rsp_vld, rsp_exc, rsp_data
	);
	modport detector (
		input req_vld, req_wr, req_id, req_addr, req_data,
		output rsp_vld, rsp_exc, rsp_data
	);
endinterface

// *** verilog/gdr_master.sv ***
// master end: issues register accesses to detectors by node slot
module gdr_master
	import gdr_pkg::*;
#(
	parameter int NODES = NODE_LIMIT,
	parameter int TIMEOUT = RSP_TIMEOUT_CYC
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	gdr_link_if.master link,
	input wire logic tbl_we_i,
	input wire logic [$clog2(NODES)-1:0] tbl_node_i,
	input wire logic [ID_W-1:0] tbl_id_i,
	input wire logic cmd_vld_i,
	input wire logic [$clog2(NODES)-1:0] cmd_node_i,
	input wire logic cmd_wr_i,
	input wire logic [ADDR_W-1:0] cmd_addr_i,
	input wire logic [DATA_W-1:0] cmd_data_i,
	output logic cmd_rdy_o,
	output logic res_vld_o,
	output logic res_exc_o,
	output logic res_timeout_o,
	output logic [DATA_W-1:0] res_data_o
);
	localparam int TW = $clog2(TIMEOUT + 1);

	gdr_host_state_t state_q;
	logic [ID_W-1:0] id_tbl_q [NODES];
	logic req_vld_q;
	logic req_wr_q;
	logic [ID_W-1:0] req_id_q;
	logic [ADDR_W-1:0] req_addr_q;
	logic [DATA_W-1:0] req_data_q;
	logic [TW-1:0] wait_q;

	////////////////////////////////////////////////////////////////////////
	// station table, size bounds the segment population

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			for (int i = 0; i < NODES; i++) begin
				id_tbl_q[i] <= BROADCAST_ID;
			end
		end else if (tbl_we_i && tbl_id_i <= STATION_MAX) begin
			id_tbl_q[tbl_node_i] <= tbl_id_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// request sequencing

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			state_q <= HST_IDLE;
			cmd_rdy_o <= 1'b0;
			req_vld_q <= 1'b0;
			req_wr_q <= 1'b0;
			req_id_q <= BROADCAST_ID;
			req_addr_q <= WORD_ZERO;
			req_data_q <= WORD_ZERO;
			wait_q <= '0;
			res_vld_o <= 1'b0;
			res_exc_o <= 1'b0;
			res_timeout_o <= 1'b0;
			res_data_o <= WORD_ZERO;
		end else begin
			req_vld_q <= 1'b0;
			res_vld_o <= 1'b0;
			unique case (state_q)
				HST_IDLE: begin
					cmd_rdy_o <= 1'b1;
					if (cmd_vld_i && cmd_rdy_o) begin
						cmd_rdy_o <= 1'b0;
						req_vld_q <= 1'b1;
						req_wr_q <= cmd_wr_i;
						req_id_q <= id_tbl_q[cmd_node_i];
						req_addr_q <= cmd_addr_i;
						req_data_q <= cmd_data_i;
						state_q <= HST_SEND;
					end
				end
				HST_SEND: begin
					wait_q <= TW'(TIMEOUT);
					state_q <= HST_WAIT;
					if (req_id_q == BROADCAST_ID) begin
						res_vld_o <= 1'b1;
						res_exc_o <= 1'b0;
						res_timeout_o <= 1'b0;
						res_data_o <= req_data_q;
						state_q <= HST_IDLE;
					end
				end
				HST_WAIT: begin
					wait_q <= wait_q - TW'(1);
					if (link.rsp_vld || wait_q == '0) begin
						res_vld_o <= 1'b1;
						res_exc_o <= link.rsp_vld && link.rsp_exc;
						res_timeout_o <= !link.rsp_vld;
						res_data_o <= link.rsp_vld ? link.rsp_data : WORD_ZERO;
						state_q <= HST_IDLE;
					end
				end
				default: state_q <= HST_IDLE;
			endcase
		end
	end

	assign link.req_vld = req_vld_q;
	assign link.req_wr = req_wr_q;
	assign link.req_id = req_id_q;
	assign link.req_addr = req_addr_q;
	assign link.req_data = req_data_q;
endmodule // gdr_master

// *** verilog/gdr_pkg.sv ***
// constants and types for the gas detector register bank link
// Functional notes
// - master reaches bank over shared multidrop link
// - master serves at most 32 detectors
// - one address per register, hex equals decimal
// - master writes only the two clear registers
// - float values span two consecutive registers
// - codes single register; station address 0..247
// - days since zeroing, above 60000 means never
// - days since span, above 60000 means never
// - relay options in one read-only bit field
// - write one clears first relay; reads zero
// - write one clears second relay; reads zero
// - option bits: direction, failsafe, latch per relay
// - operating state codes 0,1,2,3,5,6,7
// - fault codes 0,1,4,5,6
package gdr_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int ID_W = 8;
	localparam int FLT_W = 32;

	////////////////////////////////////////////////////////////////////////
	// register addresses
	localparam logic [ADDR_W-1:0] GAS_CONCENTRATION_VALUE = 16'h0001;
	localparam logic [ADDR_W-1:0] STATION_ADDRESS = 16'h0003;
	localparam logic [ADDR_W-1:0] GAS_KIND = 16'h0004;
	localparam logic [ADDR_W-1:0] MEASUREMENT_UNIT_KIND = 16'h0005;
	localparam logic [ADDR_W-1:0] FIRMWARE_MAJOR_VERSION = 16'h0006;
	localparam logic [ADDR_W-1:0] FIRMWARE_MINOR_VERSION = 16'h0007;
	localparam logic [ADDR_W-1:0] OPERATING_STATE = 16'h0008;
	localparam logic [ADDR_W-1:0] SUPPLY_VOLTAGE_VALUE = 16'h0009;
	localparam logic [ADDR_W-1:0] FAULT_CAUSE = 16'h000B;
	localparam logic [ADDR_W-1:0] SENSING_TECHNOLOGY = 16'h000C;
	localparam logic [ADDR_W-1:0] FIRST_RELAY_THRESHOLD = 16'h000E;
	localparam logic [ADDR_W-1:0] SECOND_RELAY_THRESHOLD = 16'h0010;
	localparam logic [ADDR_W-1:0] DECIMAL_PLACES = 16'h0016;
	localparam logic [ADDR_W-1:0] RELAY_OPTION_BITS = 16'h0017;
	localparam logic [ADDR_W-1:0] DAYS_SINCE_ZEROING = 16'h0018;
	localparam logic [ADDR_W-1:0] CALIBRATION_METHOD = 16'h0019;
	localparam logic [ADDR_W-1:0] AUTO_SPAN_TARGET = 16'h001A;
	localparam logic [ADDR_W-1:0] DAYS_SINCE_SPAN = 16'h001C;
	localparam logic [ADDR_W-1:0] FIRST_RELAY_ACTIVE = 16'h001E;
	localparam logic [ADDR_W-1:0] SECOND_RELAY_ACTIVE = 16'h001F;
	localparam logic [ADDR_W-1:0] FIRST_RELAY_CLEAR = 16'h0020;
	localparam logic [ADDR_W-1:0] SECOND_RELAY_CLEAR = 16'h0021;

	////////////////////////////////////////////////////////////////////////
	// field layouts and limits
	localparam int OPT_LATCH_LSB = 0;
	localparam int OPT_FAILSAFE_LSB = 2;
	localparam int OPT_RISE_LSB = 4;
	localparam int OPT_W = 6;
	localparam logic [ID_W-1:0] STATION_MAX = 8'hF7;
	localparam logic [ID_W-1:0] BROADCAST_ID = 8'h00;
	localparam logic [DATA_W-1:0] DAYS_LIMIT = 16'hEA60;
	localparam logic [DATA_W-1:0] CLEAR_CMD = 16'h0001;
	localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;
	localparam logic [DATA_W-1:0] EXC_BAD_ADDRESS = 16'h0002;
	localparam logic [DATA_W-1:0] EXC_BAD_VALUE = 16'h0003;
	localparam int NODE_LIMIT = 32;
	localparam int RSP_TIMEOUT_CYC = 64;

	////////////////////////////////////////////////////////////////////////
	// enumerations
	typedef enum logic [2:0] {
		OPST_NORMAL = 3'b000,
		OPST_ZEROING = 3'b001,
		OPST_CALIBRATION = 3'b010,
		OPST_RELAY_TEST = 3'b011,
		OPST_DIAGNOSTIC = 3'b101,
		OPST_ADVANCED = 3'b110,
		OPST_ADMINISTRATOR = 3'b111
	} gdr_opstate_t;

	typedef enum logic [2:0] {
		FLT_NONE = 3'b000,
		FLT_BOARD_LOST = 3'b001,
		FLT_ELEMENT_LOST = 3'b100,
		FLT_ZEROING_ERR = 3'b101,
		FLT_CALIBRATION_ERR = 3'b110
	} gdr_fault_t;

	typedef enum logic [1:0] {
		HST_IDLE = 2'b00,
		HST_SEND = 2'b01,
		HST_WAIT = 2'b10
	} gdr_host_state_t;
endpackage

// *** verilog/gdr_relay_latch.sv ***
// relay active state with latch, direction and failsafe options
module gdr_relay_latch
	import gdr_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic above_i,
	input wire logic rise_i,
	input wire logic latch_i,
	input wire logic failsafe_i,
	input wire logic clear_i,
	output logic active_o,
	output logic coil_o
);
	logic trip;

	assign trip = rise_i ? above_i : ~above_i;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			active_o <= 1'b0;
		end else if (trip) begin
			active_o <= 1'b1;
		end else if (!latch_i || clear_i) begin
			active_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			coil_o <= 1'b0;
		end else begin
			coil_o <= (trip || (latch_i && active_o && !clear_i)) ^ failsafe_i;
		end
	end
endmodule // gdr_relay_latch
